// ---- wol_pkg.sv ----
// Constants, register map and carrier types for the wake receive registers.
// Assumes a 16-bit APB byte address; each 16-bit register owns one word.

package wol_pkg;

	// ********************************
	// Bus shape
	// ********************************
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned REG_W = 16;
	localparam int unsigned IDX_W = 12;
	localparam int unsigned RW_COUNT = 8;

	// ********************************
	// Register indices (byte address = 4 x index)
	// ********************************
	localparam logic [IDX_W-1:0] IDX_CONFIG = 12'h4A0;
	localparam logic [IDX_W-1:0] IDX_STATUS = 12'h4A1;
	localparam logic [IDX_W-1:0] IDX_ADDR_HIGH = 12'h4A2;
	localparam logic [IDX_W-1:0] IDX_ADDR_MID = 12'h4A3;
	localparam logic [IDX_W-1:0] IDX_ADDR_LOW = 12'h4A4;
	localparam logic [IDX_W-1:0] IDX_PW_0 = 12'h4A5;
	localparam logic [IDX_W-1:0] IDX_PW_1 = 12'h4A6;
	localparam logic [IDX_W-1:0] IDX_PW_2 = 12'h4A7;
	localparam logic [IDX_W-1:0] IDX_PATTERN = 12'h4A8;

	// Slot order of the plain read/write registers
	localparam int unsigned SLOT_CONFIG = 0;
	localparam int unsigned SLOT_ADDR_HIGH = 1;
	localparam int unsigned SLOT_ADDR_MID = 2;
	localparam int unsigned SLOT_ADDR_LOW = 3;
	localparam int unsigned SLOT_PW_0 = 4;
	localparam int unsigned SLOT_PW_1 = 5;
	localparam int unsigned SLOT_PW_2 = 6;
	localparam int unsigned SLOT_PATTERN = 7;
	localparam logic [IDX_W-1:0] RW_IDX [0:RW_COUNT-1] = '{
		IDX_CONFIG, IDX_ADDR_HIGH, IDX_ADDR_MID, IDX_ADDR_LOW,
		IDX_PW_0, IDX_PW_1, IDX_PW_2, IDX_PATTERN};

	// ********************************
	// Field positions
	// ********************************
	localparam int unsigned CFG_SFD_SELECT = 13;
	localparam int unsigned CFG_CRC_GATE = 12;
	localparam int unsigned CFG_WOL_ENABLE = 7;
	localparam int unsigned CFG_PW_ENABLE = 5;
	localparam int unsigned ST_SOURCE_SELECT = 12;
	localparam int unsigned ST_SFD_ERROR = 7;
	localparam int unsigned ST_CRC_BAD = 6;
	localparam int unsigned ST_PW_BAD = 5;
	localparam int unsigned ST_PATTERN = 1;
	localparam int unsigned ST_WAKE = 0;
	localparam int unsigned FLAG_COUNT = 5;

	// ********************************
	// Reset values and codes
	// ********************************
	localparam logic [REG_W-1:0] CONFIG_RESET = 16'h1000;
	localparam logic [REG_W-1:0] ZERO_RESET = 16'h0000;
	localparam logic [REG_W-1:0] RW_RESET [0:RW_COUNT-1] = '{
		CONFIG_RESET, ZERO_RESET, ZERO_RESET, ZERO_RESET,
		ZERO_RESET, ZERO_RESET, ZERO_RESET, ZERO_RESET};
	localparam logic [7:0] SFD_SWAPPED = 8'h5D;
	localparam logic [7:0] SFD_NORMAL = 8'hD5;
	localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

	// ********************************
	// Carriers
	// ********************************
	typedef struct packed {
		logic sfd_error;
		logic crc_bad;
		logic password_bad;
		logic pattern_hit;
		logic wake_hit;
	} wol_events_s;

	typedef struct packed {
		logic [47:0] dest_addr;
		logic [47:0] password;
		logic [15:0] pattern;
		logic [7:0] sfd_value;
		logic wol_enable;
		logic password_enable;
	} wol_match_s;

	typedef enum logic [1:0] {
		WOL_BUS_IDLE = 2'b01,
		WOL_BUS_RESP = 2'b10
	} wol_bus_state_e;

endpackage : wol_pkg

// ---- wol_reg16.sv ----
// One 16-bit read/write register with byte lanes.
// Assumes write strobe and lanes qualified by the bus slave.

`timescale 1ns/1ps

module wol_reg16
	import wol_pkg::*;
#(
	parameter logic [REG_W-1:0] RESET = ZERO_RESET
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr,
	input wire logic [1:0] lanes,
	input wire logic [REG_W-1:0] wdata,
	output logic [REG_W-1:0] q
);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= RESET;
		end else if (wr) begin
			if (lanes[0]) begin
				q[7:0] <= wdata[7:0];
			end
			if (lanes[1]) begin
				q[15:8] <= wdata[15:8];
			end
		end
	end

endmodule : wol_reg16

// ---- wol_flag.sv ----
// Latch-high status flag, cleared by a status read.
// Assumes set and clear are single-cycle qualified terms.

`timescale 1ns/1ps

module wol_flag (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic set,
	input wire logic clr,
	output logic q
);

	// Set beats clear so an event in the read cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end

endmodule : wol_flag

// ---- wol_match_status.sv ----
// Wake receive status and match configuration registers behind APB.
// Assumes event pulses from the detection engine, synchronous to pclk.

`timescale 1ns/1ps

module wol_match_status
	import wol_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire wol_events_s rx_events,
	input wire logic data_polarity_irq,
	output wol_match_s match_cfg,
	output logic irq_bit1_source
);

	// ********************************
	// Bus decode
	// ********************************
	wol_bus_state_e state;
	logic [IDX_W-1:0] idx;
	logic aligned;
	logic take;
	logic hit_status;
	logic [RW_COUNT-1:0] hit_rw;
	logic mapped;
	logic do_write;
	logic rd_clear;
	logic [REG_W-1:0] rw_q [0:RW_COUNT-1];
	logic [REG_W-1:0] status_word;
	logic [REG_W-1:0] rw_word;

	assign idx = paddr[IDX_W+1:2];
	assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:IDX_W+2] == 2'h0);
	// Request taken once; the answer follows one cycle later
	assign take = psel && penable && (state == WOL_BUS_IDLE);
	assign hit_status = aligned && (idx == IDX_STATUS);
	assign mapped = hit_status || (hit_rw != '0);
	assign do_write = take && pwrite && mapped;
	assign rd_clear = take && !pwrite && hit_status;

	always_comb begin
		rw_word = ZERO_RESET;
		for (int i = 0; i < RW_COUNT; i++) begin
			hit_rw[i] = aligned && (idx == RW_IDX[i]);
			if (hit_rw[i]) begin
				rw_word = rw_q[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= WOL_BUS_IDLE;
		end else begin
			unique case (state)
				WOL_BUS_IDLE: begin
					if (take) begin
						state <= WOL_BUS_RESP;
					end
				end
				WOL_BUS_RESP: begin
					state <= WOL_BUS_IDLE;
				end
				default: begin
					state <= WOL_BUS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= READ_ZERO;
		end else begin
			pready <= take;
			pslverr <= take && !mapped;
			if (take && !pwrite) begin
				prdata <= {16'h0000, hit_status ? status_word : rw_word};
			end
		end
	end

	// ********************************
	// Read/write registers
	// ********************************
	genvar g;
	generate
		for (g = 0; g < RW_COUNT; g++) begin : g_rw
			wol_reg16 #(
				.RESET(RW_RESET[g])
			) u_reg (
				.pclk(pclk),
				.presetn(presetn),
				.wr(do_write && hit_rw[g]),
				.lanes(pstrb[1:0]),
				.wdata(pwdata[REG_W-1:0]),
				.q(rw_q[g])
			);
		end
	endgenerate

	logic [REG_W-1:0] cfg;
	assign cfg = rw_q[SLOT_CONFIG];

	// ********************************
	// Event qualification
	// ********************************
	logic crc_gated;
	logic pw_fail;
	logic [FLAG_COUNT-1:0] set_vec;
	logic [FLAG_COUNT-1:0] flag_q;
	logic wake_event;

	assign crc_gated = cfg[CFG_CRC_GATE] && rx_events.crc_bad;
	assign pw_fail = cfg[CFG_PW_ENABLE] && rx_events.password_bad;
	// Order: sfd, crc, password, pattern, wake
	assign set_vec[4] = rx_events.sfd_error;
	assign set_vec[3] = rx_events.crc_bad;
	assign set_vec[2] = cfg[CFG_WOL_ENABLE] && rx_events.wake_hit
		&& pw_fail && !crc_gated;
	assign set_vec[1] = cfg[CFG_WOL_ENABLE] && rx_events.pattern_hit
		&& !crc_gated;
	assign set_vec[0] = cfg[CFG_WOL_ENABLE] && rx_events.wake_hit
		&& !pw_fail && !crc_gated;
	assign wake_event = set_vec[1] || set_vec[0];

	generate
		for (g = 0; g < FLAG_COUNT; g++) begin : g_flag
			wol_flag u_flag (
				.pclk(pclk),
				.presetn(presetn),
				.set(set_vec[g]),
				.clr(rd_clear),
				.q(flag_q[g])
			);
		end
	endgenerate

	// ********************************
	// Interrupt source select
	// ********************************
	logic source_select;
	logic wol_turn_on;

	// Rising enable only arrives through a config write
	assign wol_turn_on = do_write && hit_rw[SLOT_CONFIG] && pstrb[0]
		&& pwdata[CFG_WOL_ENABLE] && !cfg[CFG_WOL_ENABLE];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_select <= 1'b0;
		end else if (wol_turn_on) begin
			source_select <= 1'b1;
		end else if (do_write && hit_status && pstrb[1]) begin
			source_select <= pwdata[ST_SOURCE_SELECT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_bit1_source <= 1'b0;
		end else begin
			irq_bit1_source <= source_select ? wake_event
				: data_polarity_irq;
		end
	end

	always_comb begin
		status_word = ZERO_RESET;
		status_word[ST_SOURCE_SELECT] = source_select;
		status_word[ST_SFD_ERROR] = flag_q[4];
		status_word[ST_CRC_BAD] = flag_q[3];
		status_word[ST_PW_BAD] = flag_q[2];
		status_word[ST_PATTERN] = flag_q[1];
		status_word[ST_WAKE] = flag_q[0];
	end

	// ********************************
	// Match configuration to detector
	// ********************************
	logic [7:0] sfd_value;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sfd_value <= SFD_NORMAL;
		end else begin
			sfd_value <= cfg[CFG_SFD_SELECT] ? SFD_SWAPPED : SFD_NORMAL;
		end
	end

	// Password byte n sits at bits 8n+7:8n; each address word enters with its two bytes swapped
	assign match_cfg.dest_addr = {
		rw_q[SLOT_ADDR_HIGH][7:0], rw_q[SLOT_ADDR_HIGH][15:8],
		rw_q[SLOT_ADDR_MID][7:0], rw_q[SLOT_ADDR_MID][15:8],
		rw_q[SLOT_ADDR_LOW][7:0], rw_q[SLOT_ADDR_LOW][15:8]};
	assign match_cfg.password = {rw_q[SLOT_PW_2], rw_q[SLOT_PW_1],
		rw_q[SLOT_PW_0]};
	assign match_cfg.pattern = rw_q[SLOT_PATTERN];
	assign match_cfg.sfd_value = sfd_value;
	assign match_cfg.wol_enable = cfg[CFG_WOL_ENABLE];
	assign match_cfg.password_enable = cfg[CFG_PW_ENABLE];

	// ********************************
	// Assertions
	// ********************************
	property p_irq_source;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> irq_bit1_source == $past(source_select ? wake_event
			: data_polarity_irq);
	endproperty
	a_irq_source: assert property (p_irq_source)
		else $error("irq bit 1 source mux wrong");

	property p_auto_select;
		@(posedge pclk) disable iff (!presetn)
		$rose(cfg[CFG_WOL_ENABLE]) |-> source_select;
	endproperty
	a_auto_select: assert property (p_auto_select)
		else $error("source select not set on wake enable");

	property p_latch;
		@(posedge pclk) disable iff (!presetn)
		(set_vec != '0) |=> ((flag_q & $past(set_vec)) == $past(set_vec));
	endproperty
	a_latch: assert property (p_latch)
		else $error("status flag did not latch its event");

	property p_pattern_hold;
		@(posedge pclk) disable iff (!presetn)
		flag_q[1] && !rd_clear |=> flag_q[1];
	endproperty
	a_pattern_hold: assert property (p_pattern_hold)
		else $error("pattern flag dropped without a read");

	property p_read_clear;
		@(posedge pclk) disable iff (!presetn)
		rd_clear && (set_vec == '0) |=> (flag_q == '0);
	endproperty
	a_read_clear: assert property (p_read_clear)
		else $error("status read did not clear flags");

	property p_crc_gate;
		@(posedge pclk) disable iff (!presetn)
		crc_gated && !flag_q[0] |=> !flag_q[0];
	endproperty
	a_crc_gate: assert property (p_crc_gate)
		else $error("bad CRC frame raised wake status");

	property p_disabled;
		@(posedge pclk) disable iff (!presetn)
		!cfg[CFG_WOL_ENABLE] && !flag_q[1] |=> !flag_q[1];
	endproperty
	a_disabled: assert property (p_disabled)
		else $error("pattern status set while disabled");

	property p_password;
		@(posedge pclk) disable iff (!presetn)
		!cfg[CFG_PW_ENABLE] && !flag_q[2] |=> !flag_q[2];
	endproperty
	a_password: assert property (p_password)
		else $error("password flag set while checking off");

	property p_sfd;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> sfd_value == ($past(cfg[CFG_SFD_SELECT]) ? SFD_SWAPPED
			: SFD_NORMAL);
	endproperty
	a_sfd: assert property (p_sfd)
		else $error("delimiter value wrong");

	property p_pattern_write;
		@(posedge pclk) disable iff (!presetn)
		do_write && hit_rw[SLOT_PATTERN] && (pstrb[1:0] == 2'h3)
		|=> match_cfg.pattern == $past(pwdata[REG_W-1:0]);
	endproperty
	a_pattern_write: assert property (p_pattern_write)
		else $error("pattern word not written");

	property p_answer;
		@(posedge pclk) disable iff (!presetn)
		take |=> pready ##1 !pready;
	endproperty
	a_answer: assert property (p_answer)
		else $error("bus answer not one cycle after take");

	c_read_clear: cover property (@(posedge pclk) disable iff (!presetn)
		rd_clear && (flag_q != '0));
	c_turn_on: cover property (@(posedge pclk) disable iff (!presetn)
		wol_turn_on);
	c_set_wins: cover property (@(posedge pclk) disable iff (!presetn)
		rd_clear && (set_vec != '0));
	c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
		take && !mapped);

endmodule : wol_match_status

// ---- wol_event_src.sv ----
// Event source standing in for the frame detector on the receive side.
// Assumes one-cycle requests from the bench, synchronous to pclk.

`timescale 1ns/1ps

module wol_event_src
	import wol_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic go,
	input wire wol_events_s req,
	output wol_events_s rx_events
);

	// ********************************
	// Pulse generation
	// ********************************
	// Holds each pulse as long as go stays high; a one-cycle go gives a one-cycle pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_events <= '0;
		end else begin
			rx_events <= go ? req : '0;
		end
	end

endmodule : wol_event_src

// ---- testbench.sv ----
// Self-checking bench for the wake receive status and match registers.
// Assumes the package, the design and the event source are compiled first.

`timescale 1ns/1ps

module testbench
	import wol_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, go, dp_irq, err;
	logic pready, pslverr, irq_src, irq_seen;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	wol_events_s req, rx_events;
	wol_match_s match_cfg;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;

	wol_match_status i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rx_events(rx_events), .data_polarity_irq(dp_irq),
		.match_cfg(match_cfg), .irq_bit1_source(irq_src));

	wol_event_src i_src (.pclk(pclk), .presetn(presetn), .go(go),
		.req(req), .rx_events(rx_events));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// ********************************
	// Shared tasks
	// ********************************
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Entered just after a rising edge; leaves one edge after release
	task automatic apb(input logic wr, input logic [IDX_W-1:0] idx,
		input logic [15:0] wd, input logic [3:0] st);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {16'h0000, wd};
		pstrb <= st;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait count here; a hang is left to the bench timeout
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic st(input logic [15:0] e);
		apb(1'b0, IDX_STATUS, 16'h0000, 4'h0);
		chk(rd, e);
	endtask : st

	// Irq output sampled in the cycle after the event is taken
	task automatic ev(input logic [4:0] e);
		req <= e;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		@(posedge pclk);
		irq_seen = irq_src;
	endtask : ev

	// ********************************
	// Scenarios
	// ********************************
	task automatic t_reset();
		for (int i = 0; i < RW_COUNT; i++) begin
			apb(1'b0, RW_IDX[i], 16'h0000, 4'h0);
			chk(rd, RW_RESET[i]);
		end
		st(16'h0000);
		chk(match_cfg.sfd_value, 8'hD5);
		chk(match_cfg.wol_enable, 1'b0);
	endtask : t_reset

	task automatic t_words();
		apb(1'b1, IDX_ADDR_HIGH, 16'h00A5, 4'h1);
		apb(1'b1, IDX_ADDR_HIGH, 16'hA400, 4'h2);
		apb(1'b1, IDX_ADDR_MID, 16'hA2A3, 4'hF);
		apb(1'b1, IDX_ADDR_LOW, 16'hA0A1, 4'hF);
		apb(1'b1, IDX_PW_0, 16'hB1B0, 4'hF);
		apb(1'b1, IDX_PW_1, 16'hB3B2, 4'hF);
		apb(1'b1, IDX_PW_2, 16'hB5B4, 4'hF);
		apb(1'b1, IDX_PATTERN, 16'hC1C0, 4'hF);
		apb(1'b0, IDX_ADDR_HIGH, 16'h0000, 4'h0);
		chk(rd, 48'hA4A5);
		apb(1'b0, IDX_PW_2, 16'h0000, 4'h0);
		chk(rd, 48'hB5B4);
		chk(match_cfg.dest_addr, 48'hA5A4A3A2A1A0);
		chk(match_cfg.password, 48'hB5B4B3B2B1B0);
		chk(match_cfg.pattern, 48'hC1C0);
	endtask : t_words

	task automatic t_refuse();
		apb(1'b1, 12'h4A9, 16'h1234, 4'hF);
		chk(err, 1'b1);
		apb(1'b0, IDX_PATTERN, 16'h0000, 4'h0);
		chk(err, 1'b0);
		chk(rd, 48'hC1C0);
		apb(1'b1, IDX_CONFIG, 16'h3000, 4'hF);
		chk(match_cfg.sfd_value, 8'h5D);
		apb(1'b1, IDX_CONFIG, 16'h1000, 4'hF);
		chk(match_cfg.sfd_value, 8'hD5);
	endtask : t_refuse

	// Wake detection still off here
	task automatic t_quiet();
		apb(1'b1, IDX_STATUS, 16'hFFFF, 4'hF);
		st(16'h1000);
		apb(1'b1, IDX_STATUS, 16'h0000, 4'hF);
		ev(5'h10);
		st(16'h0080);
		st(16'h0000);
		ev(5'h08);
		st(16'h0040);
		ev(5'h07);
		st(16'h0000);
		dp_irq <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(irq_src, 1'b1);
		dp_irq <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(irq_src, 1'b0);
	endtask : t_quiet

	task automatic t_wake();
		apb(1'b1, IDX_CONFIG, 16'h10A0, 4'hF);
		chk(match_cfg.wol_enable, 1'b1);
		chk(match_cfg.password_enable, 1'b1);
		st(16'h1000);
		ev(5'h01);
		chk(irq_seen, 1'b1);
		st(16'h1001);
		ev(5'h02);
		st(16'h1002);
		ev(5'h09);
		chk(irq_seen, 1'b0);
		st(16'h1040);
		ev(5'h05);
		st(16'h1020);
		apb(1'b1, IDX_CONFIG, 16'h0080, 4'hF);
		chk(match_cfg.password_enable, 1'b0);
		ev(5'h0D);
		st(16'h1041);
	endtask : t_wake

	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	// Run needs well under a thousand cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			$display("[FAIL] %0t timeout", $time);
			wrap_up();
		end
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'h0;
		go = 1'b0;
		req = '0;
		dp_irq = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_words();
		t_refuse();
		t_quiet();
		t_wake();
		wrap_up();
	end

endmodule : testbench
